// ===== hdl/acpc_regs.vh
// Constants for the converter pin control block
`ifndef ACPC_REGS_VH
`define ACPC_REGS_VH

// ==========================================================
// Conversion timing (internal oscillator)
`define ACPC_CONV_TIME_NS    660
`define ACPC_CLK_PERIOD_NS   40
`define ACPC_CONV_CYCLES     ((`ACPC_CONV_TIME_NS + `ACPC_CLK_PERIOD_NS - 1) \
                              / `ACPC_CLK_PERIOD_NS)
`define ACPC_OSC_DIV         2

// ==========================================================
// Reset values and the bypass gain factor
`define ACPC_CHAN_RST        3'h0
`define ACPC_GAIN_RST        3'h0
`define ACPC_GAIN_BYPASS     5'h00

// ==========================================================
// Gain code table, gain factor per code
`define ACPC_GAIN_C0         5'h01
`define ACPC_GAIN_C1         5'h02
`define ACPC_GAIN_C2         5'h03
`define ACPC_GAIN_C3         5'h04
`define ACPC_GAIN_C4         5'h06
`define ACPC_GAIN_C5         5'h08
`define ACPC_GAIN_C6         5'h0c
`define ACPC_GAIN_C7         5'h10

`endif

// ===== hdl/acpc_osc_timer.v
// Conversion timer driven by the internal oscillator enable
`timescale 1ns/1ps
`include "acpc_regs.vh"

module acpc_osc_timer #(
  parameter DIV    = `ACPC_OSC_DIV,
  parameter CYCLES = `ACPC_CONV_CYCLES
) (
  input  wire ref_clk,   // System clock
  input  wire nrst,      // Sync reset, active low
  input  wire start,     // Begin timing a conversion
  input  wire abort,     // Cancel the conversion
  output reg  busy_r,    // Conversion running
  output reg  done_r     // One-cycle end pulse
);

  reg [7:0] div_r;
  reg [7:0] cnt_r;
  wire      tick;

  // ==========================================================
  // Oscillator enable; free running, not tied to any serial clock
  assign tick = (div_r == (DIV[7:0] - 8'h01));

  always @(posedge ref_clk) begin
    if (!nrst) begin
      div_r  <= 8'h00;
      cnt_r  <= 8'h00;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      div_r  <= tick ? 8'h00 : div_r + 8'h01;
      if (abort) begin
        busy_r <= 1'b0;
        cnt_r  <= 8'h00;
      end else if (start) begin
        busy_r <= 1'b1;
        cnt_r  <= 8'h00;
      end else if (busy_r && tick) begin
        if (cnt_r == (CYCLES[7:0] - 8'h01)) begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
        end else begin
          cnt_r <= cnt_r + 8'h01;
        end
      end
    end
  end

endmodule

// ===== hdl/acpc_pin_control.v
// Pin level control of the eight channel converter
// What this block does
// - Each falling edge of convert_start_bar begins a conversion unless powered down.
// - Conversions are timed by an internal oscillator, not a serial clock.
// - Output driver off while convert_start_bar high; on when low unless powered down.
// - Power-down during a conversion aborts it and keeps output floating.
// - Normal mode wake: data and selections valid one sample later.
// - Low-power wake: first sample valid, selections apply to it.
// - power_down_n defaults to operating when undriven (pull-up).
// - amp_bypass high routes the mux straight to the converter.
// - Bypass ignores gain select bits; gain resumes when bypass drops.
// - Scan starts at channel 0 on next rising edge, then advances.
// - Scan cycles channels 0 to 7 repeatedly while scan is high.
// - In scan mode the channel select bits are ignored.
// - Without scan, channel equals select bits 2,1,0, bit 2 MSB.
// - Gain codes 0 to 7 map to gains 1,2,3,4,6,8,12,16.
// - Select levels captured on convert_start_bar rising edge, held.
`timescale 1ns/1ps
`include "acpc_regs.vh"

module acpc_pin_control (
  input  wire       ref_clk,           // 25 MHz clock
  input  wire       nrst,              // Sync reset, active low
  input  wire       convert_start_bar, // Convert start, active low
  input  wire       power_down_n,      // Power down, active low
  input  wire       power_down_n_oe_n, // Low when host drives power_down_n
  input  wire       low_power_select,  // Low-power mode select
  input  wire       amp_bypass,        // Skip the gain stage
  input  wire       scan_mode,         // Channel sequencer enable
  input  wire       chan_select_bit2,  // Channel select MSB
  input  wire       chan_select_bit1,  // Channel select
  input  wire       chan_select_bit0,  // Channel select LSB
  input  wire       gain_select_bit2,  // Gain select MSB
  input  wire       gain_select_bit1,  // Gain select
  input  wire       gain_select_bit0,  // Gain select LSB
  input  wire       result_bit,        // Serial result bit to present
  output reg        serial_data_out,   // Serial data output value
  output wire       serial_data_oe_n,  // Output enable, low drives
  output reg  [2:0] active_chan_r,     // Channel on the converter
  output reg  [4:0] active_gain_r,     // Gain factor, zero when bypassed
  output reg        pga_path_r,        // High when gain stage in path
  output wire       conv_busy,         // Conversion running
  output reg        data_valid_r,      // Result of last conversion is valid
  output reg        powered_down_r     // Device held in power-down
);

  // ==========================================================
  // Gain decode
  function [4:0] acpc_gain;
    input [2:0] code;
    begin
      case (code)
        3'h0:    acpc_gain = `ACPC_GAIN_C0;
        3'h1:    acpc_gain = `ACPC_GAIN_C1;
        3'h2:    acpc_gain = `ACPC_GAIN_C2;
        3'h3:    acpc_gain = `ACPC_GAIN_C3;
        3'h4:    acpc_gain = `ACPC_GAIN_C4;
        3'h5:    acpc_gain = `ACPC_GAIN_C5;
        3'h6:    acpc_gain = `ACPC_GAIN_C6;
        default: acpc_gain = `ACPC_GAIN_C7;
      endcase
    end
  endfunction

  // Next sequencer channel; the first rise of a scan run gives 0
  function [2:0] acpc_seq_next;
    input       armed;
    input [2:0] chan;
    begin
      if (armed)
        acpc_seq_next = chan + 3'h1;
      else
        acpc_seq_next = `ACPC_CHAN_RST;
    end
  endfunction

  // ==========================================================
  // Input conditioning
  reg        csb_d_r;
  reg        scan_d_r;
  reg  [2:0] chan_lat_r;
  reg  [2:0] gain_lat_r;
  reg        byp_lat_r;
  reg  [2:0] seq_chan_r;
  reg        seq_armed_r;
  reg        wake_pend_r;
  reg        first_r;
  wire       pd_eff;
  wire       csb_fall;
  wire       csb_rise;
  wire       scan_rise;
  wire       abort;
  wire       conv_done;
  wire [2:0] pin_chan;
  wire [2:0] pin_gain;
  wire [2:0] use_chan;
  wire       cap_rise;

  // Undriven pin reads as operating, like a pull-up
  assign pd_eff    = power_down_n_oe_n ? 1'b1 : power_down_n;
  assign csb_fall  = csb_d_r & ~convert_start_bar;
  assign csb_rise  = ~csb_d_r & convert_start_bar;
  assign scan_rise = scan_mode & ~scan_d_r;
  assign pin_chan  = {chan_select_bit2, chan_select_bit1,
                      chan_select_bit0};
  assign pin_gain  = {gain_select_bit2, gain_select_bit1,
                      gain_select_bit0};
  assign abort     = ~pd_eff & conv_busy;
  // A scan start in the capture cycle restarts the run at channel 0
  assign use_chan  = scan_mode ? acpc_seq_next(seq_armed_r & ~scan_rise,
                                               seq_chan_r)
                               : pin_chan;
  assign cap_rise  = csb_rise & pd_eff;

  // ==========================================================
  // Conversion timer
  acpc_osc_timer u_timer (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .start   (csb_fall & pd_eff),
    .abort   (abort),
    .busy_r  (conv_busy),
    .done_r  (conv_done)
  );

  // ==========================================================
  // Output driver: high-Z when start high or powered down
  assign serial_data_oe_n = convert_start_bar | ~pd_eff;

  // ==========================================================
  // Pin history for edge detection
  always @(posedge ref_clk) begin
    if (!nrst) begin
      csb_d_r        <= 1'b0;
      scan_d_r       <= 1'b0;
      powered_down_r <= 1'b0;
    end else begin
      csb_d_r        <= convert_start_bar;
      scan_d_r       <= scan_mode;
      powered_down_r <= ~pd_eff;
    end
  end

  // ==========================================================
  // Serial output register; the driver enable is kept apart
  always @(posedge ref_clk) begin
    if (!nrst) begin
      serial_data_out <= 1'b0;
    end else begin
      serial_data_out <= result_bit;
    end
  end

  // ==========================================================
  // Sequencer; a new scan run always restarts from channel 0
  always @(posedge ref_clk) begin
    if (!nrst) begin
      seq_chan_r  <= `ACPC_CHAN_RST;
      seq_armed_r <= 1'b0;
    end else if (cap_rise && scan_mode) begin
      seq_chan_r  <= use_chan;
      seq_armed_r <= 1'b1;
    end else if (scan_rise) begin
      seq_chan_r  <= `ACPC_CHAN_RST;
      seq_armed_r <= 1'b0;
    end
  end

  // ==========================================================
  // Capture of the select pins at each rise of convert start unless powered down
  always @(posedge ref_clk) begin
    if (!nrst) begin
      chan_lat_r <= `ACPC_CHAN_RST;
      gain_lat_r <= `ACPC_GAIN_RST;
      byp_lat_r  <= 1'b0;
    end else if (cap_rise) begin
      chan_lat_r <= use_chan;
      gain_lat_r <= pin_gain;
      byp_lat_r  <= amp_bypass;
    end
  end

  // ==========================================================
  // Application: low power uses this capture, normal the one before
  always @(posedge ref_clk) begin
    if (!nrst) begin
      active_chan_r <= `ACPC_CHAN_RST;
      active_gain_r <= `ACPC_GAIN_C0;
      pga_path_r    <= 1'b1;
    end else if (cap_rise && low_power_select) begin
      active_chan_r <= use_chan;
      pga_path_r    <= ~amp_bypass;
      active_gain_r <= amp_bypass ? `ACPC_GAIN_BYPASS
                                  : acpc_gain(pin_gain);
    end else if (cap_rise) begin
      active_chan_r <= chan_lat_r;
      pga_path_r    <= ~byp_lat_r;
      active_gain_r <= byp_lat_r ? `ACPC_GAIN_BYPASS
                                 : acpc_gain(gain_lat_r);
    end
  end

  // ==========================================================
  // Wake tracking and result validity
  always @(posedge ref_clk) begin
    if (!nrst) begin
      wake_pend_r  <= 1'b0;
      first_r      <= 1'b0;
      data_valid_r <= 1'b0;
    end else begin
      if (!pd_eff)
        wake_pend_r <= 1'b1;
      else if (cap_rise)
        wake_pend_r <= 1'b0;
      // A finishing conversion wins over power-down in the same cycle
      if (conv_done)
        data_valid_r <= ~first_r;
      else if (!pd_eff)
        data_valid_r <= 1'b0;
      // Wake capture wins over a done, so in normal mode the next result is marked
      if (cap_rise && wake_pend_r)
        first_r <= ~low_power_select;
      else if (conv_done)
        first_r <= 1'b0;
    end
  end

endmodule

// ===== verif/acpc_pin_control_props.sv
// Port checker of the converter pin control block
`timescale 1ns/1ps
module acpc_pin_control_props (
  input wire       ref_clk,           // Clock
  input wire       nrst,              // Sync reset
  input wire       convert_start_bar, // Convert start
  input wire       power_down_n,      // Power down pin
  input wire       power_down_n_oe_n, // High when pin floats
  input wire       serial_data_oe_n,  // Output enable
  input wire [4:0] active_gain_r,     // Applied gain
  input wire [2:0] active_chan_r,     // Applied channel
  input wire       pga_path_r,        // Gain stage in path
  input wire       conv_busy,         // Conversion running
  input wire       powered_down_r     // Power-down status
);
  wire      pd_eff = power_down_n | power_down_n_oe_n;
  reg [6:0] bcnt_r;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // ==================================================
  // Busy length, saturating so it cannot wrap
  always @(posedge ref_clk) begin
    if (!nrst || !conv_busy) bcnt_r <= 7'h00;
    else if (bcnt_r != 7'h7f) bcnt_r <= bcnt_r + 7'h01;
  end
  sequence s_fall;
    $fell(convert_start_bar) && pd_eff && !powered_down_r;
  endsequence
  // ==================================================
  // Properties
  a_fall_busy:
    assert property (s_fall ##1 pd_eff |-> ##[0:1] conv_busy)
    else $error("no start");
  a_busy_bound:
    assert property (bcnt_r <= 7'h28) else $error("conversion too long");
  a_oe_high:
    assert property (convert_start_bar |-> serial_data_oe_n)
    else $error("oe high");
  a_oe_low:
    assert property (!convert_start_bar && pd_eff |-> !serial_data_oe_n)
    else $error("oe low");
  a_oe_pd:
    assert property (!pd_eff |-> serial_data_oe_n)
    else $error("oe in power down");
  a_pd_abort:
    assert property (conv_busy && !pd_eff |=> !conv_busy) else $error("no abort");
  a_gain_code:
    assert property (pga_path_r ? active_gain_r inside {5'h01, 5'h02, 5'h03,
      5'h04, 5'h06, 5'h08, 5'h0c, 5'h10} : active_gain_r == 5'h00)
    else $error("bad gain");
  a_chan_hold:
    assert property ($changed(active_chan_r) |-> $past(convert_start_bar)
      && !$past(convert_start_bar, 4)) else $error("channel moved");
endmodule

// ===== verif/acpc_host_model.sv
// Host model framing convert start around each sample
`timescale 1ns/1ps
module acpc_host_model (
  input  wire ref_clk,           // Clock
  input  wire go,                // Request one frame
  input  wire slow,              // Longer acquisition phase
  output reg  convert_start_bar, // Convert start to device
  output wire frame_busy         // Frame in progress
);
  reg [6:0] cnt_r = 7'h00;
  initial convert_start_bar = 1'b0;
  assign frame_busy = cnt_r != 7'h00;
  // Low phase outlasts a conversion; idle level stays low
  always @(posedge ref_clk) begin
    if (frame_busy) begin
      cnt_r <= cnt_r - 7'h01;
      if (cnt_r == 7'h2d) convert_start_bar <= #1 1'b0;
    end else if (go) begin
      cnt_r <= slow ? 7'h3c : 7'h32;
      convert_start_bar <= #1 1'b1;
    end
  end
endmodule

// ===== verif/tb_acpc_pin_control.sv
// Self-checking bench of the converter pin control block
`timescale 1ns/1ps
module tb_acpc_pin_control;
  logic ref_clk, nrst, power_down_n, power_down_n_oe_n, low_power_select;
  logic amp_bypass, scan_mode, result_bit, go, slow;
  logic chan_select_bit2, chan_select_bit1, chan_select_bit0;
  logic gain_select_bit2, gain_select_bit1, gain_select_bit0;
  wire convert_start_bar, frame_busy, serial_data_out, serial_data_oe_n;
  wire conv_busy, data_valid_r, powered_down_r, pga_path_r;
  wire [2:0] active_chan_r;
  wire [4:0] active_gain_r;
  logic [31:0] seed = 32'h00004ecf;
  logic [7:0] ec, eg, ep, pc, pg, pp;
  logic [7:0] gtab [8] = '{8'h01, 8'h02, 8'h03, 8'h04,
                           8'h06, 8'h08, 8'h0c, 8'h10};
  int failures = 0, cmp_count = 0, i;
  logic rb_q, rst_q = 1'b0;
  acpc_host_model host_u (.ref_clk, .go, .slow, .convert_start_bar,
    .frame_busy);
  acpc_pin_control dut_u (.ref_clk, .nrst, .convert_start_bar,
    .power_down_n, .power_down_n_oe_n, .low_power_select, .amp_bypass,
    .scan_mode, .chan_select_bit2, .chan_select_bit1, .chan_select_bit0,
    .gain_select_bit2, .gain_select_bit1, .gain_select_bit0, .result_bit,
    .serial_data_out, .serial_data_oe_n, .active_chan_r, .active_gain_r,
    .pga_path_r, .conv_busy, .data_valid_r, .powered_down_r);
  always #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk) result_bit <= #1 seed[7];
  // ==================================================
  // Helpers
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  task chk_sel(input logic [7:0] c, input logic [7:0] g, input logic [7:0] p);
    chk("active_chan_r", c, 8'(active_chan_r));
    chk("active_gain_r", g, 8'(active_gain_r));
    chk("pga_path_r", p, 8'(pga_path_r));
  endtask
  // Serial output repeats the bit taken one edge earlier
  always @(negedge ref_clk) begin
    if (rst_q && nrst)
      chk("serial_data_out", {7'h00, rb_q}, {7'h00, serial_data_out});
    rb_q  <= result_bit;
    rst_q <= nrst;
  end
  // Random channel and bypass, given gain code; works out what applies
  task set_sel(input logic [2:0] c);
    logic [31:0] r;
    r = rnd();
    {chan_select_bit2, chan_select_bit1, chan_select_bit0} = r[2:0];
    amp_bypass = r[3];
    {gain_select_bit2, gain_select_bit1, gain_select_bit0} = c;
    ec = {5'h00, r[2:0]};
    eg = r[3] ? 8'h00 : gtab[c];
    ep = {7'h00, !r[3]};
  endtask
  task start_frame(input logic s);
    @(posedge ref_clk);
    #1 go = 1'b1;
    slow = s;
    @(posedge ref_clk);
    #1 go = 1'b0;
  endtask
  task wait_frame;
    for (int k = 0; k < 80 && frame_busy; k++) @(posedge ref_clk);
    @(posedge ref_clk);
    #1;
  endtask
  task frame(input logic s);
    start_frame(s);
    wait_frame();
  endtask
  task results;
    $display("comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ==================================================
  // Sequence
  initial begin
    {ref_clk, nrst, go, slow, scan_mode, low_power_select} = 6'h00;
    {power_down_n, power_down_n_oe_n} = 2'h2;
    set_sel(3'h0);
    repeat (12) @(posedge ref_clk);
    #1 nrst = 1'b1;
    frame(1'b0);
    {pc, pg, pp} = {ec, eg, ep};
    for (i = 0; i < 16; i++) begin
      low_power_select = i[3];
      set_sel(i[2:0]);
      frame(i[0]);
      if (i[3]) chk_sel(ec, eg, ep);
      else chk_sel(pc, pg, pp);
      chk("data_valid_r", 8'h01, 8'(data_valid_r));
      chk("serial_data_oe_n", 8'h00, 8'(serial_data_oe_n));
      {pc, pg, pp} = {ec, eg, ep};
    end
    low_power_select = 1'b0;
    start_frame(1'b0);
    repeat (14) @(posedge ref_clk);
    #1 chk("conv_busy", 8'h01, 8'(conv_busy));
    power_down_n = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 chk("conv_busy", 8'h00, 8'(conv_busy));
    chk("serial_data_oe_n", 8'h01, 8'(serial_data_oe_n));
    chk("powered_down_r", 8'h01, 8'(powered_down_r));
    wait_frame();
    power_down_n = 1'b1;
    frame(1'b1);
    chk("data_valid_r", 8'h00, 8'(data_valid_r));
    chk("powered_down_r", 8'h00, 8'(powered_down_r));
    low_power_select = 1'b1;
    power_down_n = 1'b0;
    repeat (3) @(posedge ref_clk);
    #1 power_down_n = 1'b1;
    set_sel(3'h5);
    frame(1'b0);
    chk("data_valid_r", 8'h01, 8'(data_valid_r));
    chk_sel(ec, eg, ep);
    scan_mode = 1'b1;
    power_down_n = 1'b0;
    power_down_n_oe_n = 1'b1;
    for (i = 0; i < 10; i++) begin
      set_sel(i[2:0]);
      frame(i[1]);
      chk_sel(8'(i[2:0]), eg, ep);
    end
    // Normal mode: pins resume, then a fresh scan run one sample late
    {pc, pg, pp} = {8'h01, eg, ep};
    low_power_select = 1'b0;
    scan_mode = 1'b0;
    set_sel(3'h2);
    frame(1'b0);
    chk_sel(pc, pg, pp);
    {pc, pg, pp} = {ec, eg, ep};
    scan_mode = 1'b1;
    for (i = 0; i < 10; i++) begin
      set_sel(i[2:0]);
      frame(1'b0);
      chk_sel(pc, pg, pp);
      {pc, pg, pp} = {8'(i[2:0]), eg, ep};
    end
    results();
  end
  // About 41 frames of some 60 cycles each; a wide margin over that
  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    results();
  end
endmodule
bind acpc_pin_control acpc_pin_control_props u_props (.ref_clk, .nrst,
  .convert_start_bar, .power_down_n, .power_down_n_oe_n, .serial_data_oe_n,
  .active_gain_r, .active_chan_r, .pga_path_r, .conv_busy, .powered_down_r);
